// file: rtl/drdt_regs.svh
// Register offsets, field positions, reset values and timing constants of the dual reload timer.
// Assumes a 4-bit register port with word offsets as listed here.
`ifndef DRDT_REGS_SVH
`define DRDT_REGS_SVH
`define DRDT_A_MODE 4'h0
`define DRDT_A_SRC 4'h1
`define DRDT_A_T0CTL 4'h2
`define DRDT_A_T1CTL 4'h3
`define DRDT_A_RLD0L 4'h4
`define DRDT_A_RLD0H 4'h5
`define DRDT_A_RLD1L 4'h6
`define DRDT_A_RLD1H 4'h7
`define DRDT_A_CNT0L 4'h8
`define DRDT_A_CNT0H 4'h9
`define DRDT_A_CNT1L 4'ha
`define DRDT_A_CNT1H 4'hb
`define DRDT_A_MASK 4'hc
`define DRDT_A_FLAG 4'hd
`define DRDT_B_POL 0
`define DRDT_B_FILT 1
`define DRDT_B_EVT 2
`define DRDT_B_SRC0 0
`define DRDT_B_SRC1 1
`define DRDT_B_RUN 0
`define DRDT_B_TRIG 1
`define DRDT_B_DIVLO 2
`define DRDT_B_DIVHI 3
`define DRDT_RST_NIB 4'h0
`define DRDT_RST_BYTE 8'h00
`define DRDT_HOLD_US 1000
`define DRDT_CLK_MHZ 40
`define DRDT_TICK_HZ 2048
`define DRDT_CLK_HZ 40000000
`define DRDT_DIV4 8'h03
`define DRDT_DIV32 8'h1f
`define DRDT_DIV256 8'hff
`endif

// file: rtl/drdt_pkg.sv
// Types shared by the dual reload timer.
// Assumes nothing beyond the constants header.
package drdt_pkg;
    typedef enum logic [1:0] {
        DRDT_DIV1 = 2'b00,
        DRDT_DIV4S = 2'b01,
        DRDT_DIV32S = 2'b10,
        DRDT_DIV256S = 2'b11
    } drdt_div_t;
    typedef enum logic [1:0] {
        DRDT_F_IDLE = 2'b00,
        DRDT_F_WAIT1 = 2'b01,
        DRDT_F_WAIT2 = 2'b10
    } drdt_filt_t;
endpackage

// file: rtl/drdt_timer.sv
// Two 8-bit reload down timers with event counting, noise filter and nibble read hold.
// Assumes oscillator clocks and the event pin arrive as levels sampled by ref_clk,
// and a 4-bit register port with read data one cycle after the read strobe.
//
// How it works
// RL1 - Two independent 8-bit down counters, each with an 8-bit reload value.
// RL2 - Writing one to the reload trigger copies the reload value into the counter.
// RL3 - Run control gates counting; stopping keeps the counter value.
// RL4 - Low nibble read freezes the high nibble; software reads low first.
// RL5 - On underflow the counter reloads itself and keeps counting.
// RL6 - Underflow pulse per timer sets its flag; timer 0 drives the toggle output, timer 1 the serial clock.
// RL7 - Timer 0 mode bit: zero timer, one event counting; reset gives timer.
// RL8 - Timer 1 is only a periodic prescaled timer.
// RL9 - In timer mode each counter decrements on its prescaler output.
// RL10 - Event mode counts pin transitions and ignores prescaler settings.
// RL11 - Polarity bit zero counts falling edges, one counts rising edges.
// RL12 - Filter enable inserts a chatter filter on the event input.
// RL13 - Filtered change passes at second falling edge of the 2048 Hz tick.
// RL14 - Source holds each level 0.98 ms; 0.48 ms glitches are rejected.
// RL15 - Prescaler divides by 1, 4, 32 or 256 for codes 0 to 3.
// RL16 - Source select zero picks slow oscillator, one picks fast oscillator.
// RL17 - Underflow sets the flag regardless of mask; writing one clears it.
// RL18 - Frozen high nibble releases on its read or after the hold window.
// RL19 - Event input passes two flip-flops before edge detection or filtering.
// RL20 - Trigger coinciding with underflow loads once and still pulses underflow.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "drdt_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module drdt_timer #(
    parameter int HOLD_CYC = (`DRDT_HOLD_US * `DRDT_CLK_MHZ),
    parameter int TICK_DIV = (`DRDT_CLK_HZ / `DRDT_TICK_HZ)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [3:0] reg_rdata,
    input wire logic slow_osc_clock,
    input wire logic fast_osc_clock,
    input wire logic event_input_pin,
    output logic t0_underflow,
    output logic t1_underflow,
    output logic t0_irq,
    output logic t1_irq,
    output logic underflow_toggle_out,
    output logic serial_clock_src
);
    import drdt_pkg::*;

    logic [2:0] mode_r;
    logic [1:0] src_r;
    logic [3:0] ctl0_r, ctl1_r;
    logic [7:0] t0_reload_value, t1_reload_value;
    logic [7:0] cnt0_r, cnt1_r;
    logic [1:0] mask_r, flag_r;
    logic [3:0] hold_nib_r;
    logic hold_r;
    logic [31:0] hold_cnt_r;
    logic [3:0] rdata_r;
    logic [1:0] sync_r;
    logic evt_prev_r, filt_lvl_r, filt_lvl_prev_r;
    drdt_filt_t filt_st_r;
    logic [15:0] tick_cnt_r;
    logic tick_r, tick_prev_r;
    logic [1:0] slow_prev_r, fast_prev_r;
    logic [7:0] pre0_r, pre1_r;
    logic tog0_r, tog1_r;

    wire t0_event_mode_sel = mode_r[`DRDT_B_EVT];
    wire event_edge_polarity = mode_r[`DRDT_B_POL];
    wire event_filter_enable = mode_r[`DRDT_B_FILT];
    wire t0_run_ctrl = ctl0_r[`DRDT_B_RUN];
    wire t1_run_ctrl = ctl1_r[`DRDT_B_RUN];
    wire wr_t0ctl = reg_wr && (reg_addr == `DRDT_A_T0CTL);
    wire wr_t1ctl = reg_wr && (reg_addr == `DRDT_A_T1CTL);
    // RL2 trigger on one
    wire t0_reload_trigger = wr_t0ctl && reg_wdata[`DRDT_B_TRIG];
    wire t1_reload_trigger = wr_t1ctl && reg_wdata[`DRDT_B_TRIG];
    wire rd_cnt0l = reg_rd && (reg_addr == `DRDT_A_CNT0L);
    wire rd_cnt1l = reg_rd && (reg_addr == `DRDT_A_CNT1L);
    wire rd_high = reg_rd && ((reg_addr == `DRDT_A_CNT0H) || (reg_addr == `DRDT_A_CNT1H));

    // RL16 source select
    wire slow_rise = slow_osc_clock && !slow_prev_r[0];
    wire fast_rise = fast_osc_clock && !fast_prev_r[0];
    wire src0_edge = src_r[`DRDT_B_SRC0] ? fast_rise : slow_rise;
    wire src1_edge = src_r[`DRDT_B_SRC1] ? fast_rise : slow_rise;

    // RL15 division ratio
    function automatic logic [7:0] div_top(input logic [1:0] sel);
        case (drdt_div_t'(sel))
            DRDT_DIV1: div_top = `DRDT_RST_BYTE;
            DRDT_DIV4S: div_top = `DRDT_DIV4;
            DRDT_DIV32S: div_top = `DRDT_DIV32;
            DRDT_DIV256S: div_top = `DRDT_DIV256;
            default: div_top = `DRDT_RST_BYTE;
        endcase
    endfunction
    wire [7:0] top0 = div_top(ctl0_r[`DRDT_B_DIVHI:`DRDT_B_DIVLO]);
    wire [7:0] top1 = div_top(ctl1_r[`DRDT_B_DIVHI:`DRDT_B_DIVLO]);
    // RL9 prescaler output
    wire pre0_tick = src0_edge && (pre0_r >= top0);
    wire pre1_tick = src1_edge && (pre1_r >= top1);

    // RL11 edge polarity
    wire evt_src = event_filter_enable ? filt_lvl_r : sync_r[1];
    wire evt_prv = event_filter_enable ? filt_lvl_prev_r : evt_prev_r;
    wire evt_edge = event_edge_polarity ? (evt_src && !evt_prv) : (!evt_src && evt_prv);
    // RL10 event mode clock
    wire t0_clk_en = t0_event_mode_sel ? evt_edge : pre0_tick;
    // RL3 run gate
    wire t0_dec = t0_run_ctrl && t0_clk_en;
    // RL8 timer 1 prescaled only
    wire t1_dec = t1_run_ctrl && pre1_tick;
    // RL6 underflow pulse
    assign t0_underflow = t0_dec && (cnt0_r == `DRDT_RST_BYTE);
    assign t1_underflow = t1_dec && (cnt1_r == `DRDT_RST_BYTE);
    wire tick_fall = !tick_r && tick_prev_r;

    // RL5 auto reload
    // RL20 single load
    wire [7:0] cnt0_nxt = (t0_reload_trigger || t0_underflow) ? t0_reload_value :
                          t0_dec ? cnt0_r - 8'h01 : cnt0_r;
    wire [7:0] cnt1_nxt = (t1_reload_trigger || t1_underflow) ? t1_reload_value :
                          t1_dec ? cnt1_r - 8'h01 : cnt1_r;
    // RL17 set wins over clear
    wire clr0 = reg_wr && (reg_addr == `DRDT_A_FLAG) && reg_wdata[0];
    wire clr1 = reg_wr && (reg_addr == `DRDT_A_FLAG) && reg_wdata[1];
    wire [1:0] flag_nxt = {t1_underflow || (flag_r[1] && !clr1),
                           t0_underflow || (flag_r[0] && !clr0)};

    // RL4 held high nibble
    wire [3:0] hi0 = hold_r ? hold_nib_r : cnt0_r[7:4];
    wire [3:0] hi1 = hold_r ? hold_nib_r : cnt1_r[7:4];
    logic [3:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `DRDT_A_MODE: rd_mux = {1'b0, mode_r};
            `DRDT_A_SRC: rd_mux = {2'b00, src_r};
            `DRDT_A_T0CTL: rd_mux = {ctl0_r[3:2], 1'b0, ctl0_r[0]};
            `DRDT_A_T1CTL: rd_mux = {ctl1_r[3:2], 1'b0, ctl1_r[0]};
            `DRDT_A_RLD0L: rd_mux = t0_reload_value[3:0];
            `DRDT_A_RLD0H: rd_mux = t0_reload_value[7:4];
            `DRDT_A_RLD1L: rd_mux = t1_reload_value[3:0];
            `DRDT_A_RLD1H: rd_mux = t1_reload_value[7:4];
            `DRDT_A_CNT0L: rd_mux = cnt0_r[3:0];
            `DRDT_A_CNT0H: rd_mux = hi0;
            `DRDT_A_CNT1L: rd_mux = cnt1_r[3:0];
            `DRDT_A_CNT1H: rd_mux = hi1;
            `DRDT_A_MASK: rd_mux = {2'b00, mask_r};
            `DRDT_A_FLAG: rd_mux = {2'b00, flag_r};
            default: rd_mux = `DRDT_RST_NIB;
        endcase
    end
    assign reg_rdata = rdata_r;
    // RL17 mask gates request only
    assign t0_irq = flag_r[0] && mask_r[0];
    assign t1_irq = flag_r[1] && mask_r[1];
    // RL6 divided underflow outputs
    assign underflow_toggle_out = tog0_r;
    assign serial_clock_src = tog1_r;

    // Register writes; writes to read-only offsets are ignored.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // RL7 reset to timer mode
            mode_r <= 3'h0;
            src_r <= 2'h0;
            ctl0_r <= `DRDT_RST_NIB;
            ctl1_r <= `DRDT_RST_NIB;
            t0_reload_value <= `DRDT_RST_BYTE;
            t1_reload_value <= `DRDT_RST_BYTE;
            mask_r <= 2'h0;
            rdata_r <= `DRDT_RST_NIB;
        end else begin
            if (reg_wr && reg_addr == `DRDT_A_MODE) mode_r <= reg_wdata[2:0];
            if (reg_wr && reg_addr == `DRDT_A_SRC) src_r <= reg_wdata[1:0];
            if (wr_t0ctl) ctl0_r <= {reg_wdata[3:2], 1'b0, reg_wdata[0]};
            if (wr_t1ctl) ctl1_r <= {reg_wdata[3:2], 1'b0, reg_wdata[0]};
            if (reg_wr && reg_addr == `DRDT_A_RLD0L) t0_reload_value[3:0] <= reg_wdata;
            if (reg_wr && reg_addr == `DRDT_A_RLD0H) t0_reload_value[7:4] <= reg_wdata;
            if (reg_wr && reg_addr == `DRDT_A_RLD1L) t1_reload_value[3:0] <= reg_wdata;
            if (reg_wr && reg_addr == `DRDT_A_RLD1H) t1_reload_value[7:4] <= reg_wdata;
            if (reg_wr && reg_addr == `DRDT_A_MASK) mask_r <= reg_wdata[1:0];
            rdata_r <= reg_rd ? rd_mux : `DRDT_RST_NIB;
        end
    end

    // RL1 counters and prescalers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt0_r <= `DRDT_RST_BYTE;
            cnt1_r <= `DRDT_RST_BYTE;
            pre0_r <= `DRDT_RST_BYTE;
            pre1_r <= `DRDT_RST_BYTE;
            flag_r <= 2'h0;
            tog0_r <= 1'b0;
            tog1_r <= 1'b0;
            slow_prev_r <= 2'h0;
            fast_prev_r <= 2'h0;
        end else begin
            cnt0_r <= cnt0_nxt;
            cnt1_r <= cnt1_nxt;
            flag_r <= flag_nxt;
            slow_prev_r <= {slow_prev_r[0], slow_osc_clock};
            fast_prev_r <= {fast_prev_r[0], fast_osc_clock};
            // The prescaler halts with run low, so a restart resumes its phase too.
            if (t0_run_ctrl && src0_edge) pre0_r <= pre0_tick ? `DRDT_RST_BYTE : pre0_r + 8'h01;
            if (t1_run_ctrl && src1_edge) pre1_r <= pre1_tick ? `DRDT_RST_BYTE : pre1_r + 8'h01;
            if (t0_underflow) tog0_r <= !tog0_r;
            if (t1_underflow) tog1_r <= !tog1_r;
        end
    end

    // RL18 hold release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 1'b0;
            hold_nib_r <= `DRDT_RST_NIB;
            hold_cnt_r <= 32'h0;
        end else if (rd_cnt0l || rd_cnt1l) begin
            hold_r <= 1'b1;
            hold_nib_r <= rd_cnt0l ? cnt0_r[7:4] : cnt1_r[7:4];
            hold_cnt_r <= 32'h0;
        end else if (hold_r && (rd_high || hold_cnt_r >= 32'(HOLD_CYC - 1))) begin
            hold_r <= 1'b0;
        end else if (hold_r) begin
            hold_cnt_r <= hold_cnt_r + 32'h1;
        end
    end

    // RL19 two-stage sync
    // RL12 optional filter
    // RL13 second tick fall
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_r <= 2'h0;
            evt_prev_r <= 1'b0;
            filt_lvl_r <= 1'b0;
            filt_lvl_prev_r <= 1'b0;
            filt_st_r <= DRDT_F_IDLE;
            tick_cnt_r <= 16'h0;
            tick_r <= 1'b0;
            tick_prev_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[0], event_input_pin};
            evt_prev_r <= sync_r[1];
            filt_lvl_prev_r <= filt_lvl_r;
            tick_prev_r <= tick_r;
            if (tick_cnt_r >= 16'(TICK_DIV / 2 - 1)) begin
                tick_cnt_r <= 16'h0;
                tick_r <= !tick_r;
            end else begin
                tick_cnt_r <= tick_cnt_r + 16'h1;
            end
            // RL14 short glitch dropped
            case (filt_st_r)
                DRDT_F_IDLE: if (sync_r[1] != filt_lvl_r) filt_st_r <= DRDT_F_WAIT1;
                DRDT_F_WAIT1: begin
                    if (sync_r[1] == filt_lvl_r) filt_st_r <= DRDT_F_IDLE;
                    else if (tick_fall) filt_st_r <= DRDT_F_WAIT2;
                end
                DRDT_F_WAIT2: begin
                    if (sync_r[1] == filt_lvl_r) begin
                        filt_st_r <= DRDT_F_IDLE;
                    end else if (tick_fall) begin
                        filt_lvl_r <= sync_r[1];
                        filt_st_r <= DRDT_F_IDLE;
                    end
                end
                default: filt_st_r <= DRDT_F_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/drdt_assertions.sv
// Checker for the dual reload timer, bound to its top module.
// Assumes one clock domain and the register index map of the timer.
`timescale 1ns/1ps
`default_nettype none
module drdt_checker (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_rdata,
    input wire logic t0_underflow,
    input wire logic t1_underflow,
    input wire logic t0_irq,
    input wire logic underflow_toggle_out,
    input wire logic serial_clock_src
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic mask0_r;
    logic run1_r;
    wire logic mask_wr = reg_wr && reg_addr == 4'hc;
    wire logic ctl1_wr = reg_wr && reg_addr == 4'h3;
    // The checker sees only the ports, so it shadows the timer 0 mask bit and the timer 1 run bit itself.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask0_r <= 1'b0;
            run1_r <= 1'b0;
        end else begin
            if (mask_wr) mask0_r <= reg_wdata[0];
            if (ctl1_wr) run1_r <= reg_wdata[0];
        end
    end
    property p_rd_idle; !reg_rd |=> reg_rdata == 4'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_trig_rd; reg_rd && reg_addr[3:1] == 3'h1 |=> !reg_rdata[1]; endproperty
    a_trig_rd: assert property (p_trig_rd) else $error("trigger bit read as one");
    property p_uf_pulse; t0_underflow |=> !t0_underflow; endproperty
    a_uf_pulse: assert property (p_uf_pulse) else $error("underflow pulse too long");
    property p_tog; t0_underflow |=> underflow_toggle_out != $past(underflow_toggle_out); endproperty
    a_tog: assert property (p_tog) else $error("toggle output missed");
    property p_tog_hold; !t0_underflow |=> $stable(underflow_toggle_out); endproperty
    a_tog_hold: assert property (p_tog_hold) else $error("toggle output moved");
    property p_ser; t1_underflow |=> serial_clock_src != $past(serial_clock_src); endproperty
    a_ser: assert property (p_ser) else $error("serial clock missed");
    property p_irq_set; t0_underflow && mask0_r && !mask_wr |=> t0_irq; endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");
    property p_irq_fall; $fell(t0_irq) |-> $past(reg_wr) && $past(reg_addr[3:1]) == 3'h6; endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell alone");
    property p_run1; !run1_r |-> !t1_underflow; endproperty
    a_run1: assert property (p_run1) else $error("stopped timer underflowed");
    c_irq: cover property (t0_underflow && mask0_r);
    c_ser: cover property (t1_underflow);
    c_clr: cover property ($fell(t0_irq));
endmodule
bind drdt_timer drdt_checker chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_underflow(t0_underflow),
    .t1_underflow(t1_underflow), .t0_irq(t0_irq),
    .underflow_toggle_out(underflow_toggle_out), .serial_clock_src(serial_clock_src)
);
`default_nettype wire

// file: tb/drdt_event_src.sv
// Model of the external pulse source on the event input.
// Assumes the bench calls drive from its sequence; the pin idles low.
`timescale 1ns/1ps
`default_nettype none
module drdt_event_src (
    input wire logic ref_clk,
    output var logic pin
);
    initial pin = 1'b0;
    task automatic drive(input logic lvl, input int cyc);
        @(posedge ref_clk);
        pin <= lvl;
        repeat (cyc) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/test_dual_reload_down_timer.sv
// Testbench for the dual reload timer: reload, run, prescaler, event, filter and hold.
// Assumes the bound checker and the event source model beside the design.
`timescale 1ns/1ps
`default_nettype none
module test_dual_reload_down_timer;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_rdata;
    logic slow_osc_clock = 1'b0;
    logic fast_osc_clock = 1'b0;
    logic event_input_pin;
    logic t0_underflow, t1_underflow, t0_irq, t1_irq, tog_out, ser_clk;
    logic [2:0] osc_cnt = 3'h0;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    int ratio [4] = '{1, 4, 32, 256};
    drdt_timer #(.HOLD_CYC(50), .TICK_DIV(8)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .slow_osc_clock(slow_osc_clock), .fast_osc_clock(fast_osc_clock),
        .event_input_pin(event_input_pin), .t0_underflow(t0_underflow),
        .t1_underflow(t1_underflow), .t0_irq(t0_irq), .t1_irq(t1_irq),
        .underflow_toggle_out(tog_out), .serial_clock_src(ser_clk)
    );
    drdt_event_src src_u (.ref_clk(ref_clk), .pin(event_input_pin));
    always #12.5 ref_clk = ~ref_clk;
    task automatic end_sim;
        if (num_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Fast source has a period of 4 clocks, slow source 8, so periods are easy to predict.
    always @(posedge ref_clk) begin
        osc_cnt <= osc_cnt + 3'h1;
        fast_osc_clock <= osc_cnt[1];
        slow_osc_clock <= osc_cnt[2];
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [3:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(16'(reg_rdata), 16'(exp));
    endtask
    task automatic uf(input int t);
        @(negedge ref_clk);
        while ((t ? t1_underflow : t0_underflow) !== 1'b1) @(negedge ref_clk);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(4'h4, 4'h0);
        rd(4'h0, 4'h0);
        rd(4'hf, 4'h0);
        wr(4'h4, 4'h3);
        wr(4'h2, 4'h2);
        rd(4'h8, 4'h3);
        rd(4'h2, 4'h0);
        wr(4'h2, 4'h1);
        uf(0);
        wr(4'h2, 4'h0);
        repeat (40) @(posedge ref_clk);
        rd(4'h8, 4'h3);
        rd(4'hd, 4'h1);
        chk(16'(t0_irq), 16'h0);
        wr(4'hc, 4'h1);
        chk(16'(t0_irq), 16'h1);
        wr(4'hd, 4'h1);
        chk(16'(t0_irq), 16'h0);
        wr(4'h1, 4'h2);
        for (int t = 0; t < 2; t++) begin
            for (int c = 0; c < 4; c++) begin
                wr(4'(2 + t), {2'(c), 2'b11});
                uf(t);
                uf(t);
                n = cycles;
                uf(t);
                chk(16'(cycles - n), 16'(ratio[c] * (t ? 4 : 32)));
            end
            wr(4'(2 + t), 4'h0);
        end
        rd(4'hd, 4'h3);
        chk(16'(t1_irq), 16'h0);
        wr(4'hc, 4'h2);
        chk(16'(t1_irq), 16'h1);
        wr(4'hd, 4'h2);
        chk(16'(t1_irq), 16'h0);
        for (int p = 0; p < 2; p++) begin
            wr(4'h0, 4'(4 + p));
            wr(4'h2, 4'hf);
            src_u.drive(1'b1, 20);
            rd(4'h8, 4'(3 - p));
            src_u.drive(1'b0, 20);
            rd(4'h8, 4'h2);
        end
        wr(4'h0, 4'h6);
        wr(4'h2, 4'hf);
        src_u.drive(1'b1, 3);
        src_u.drive(1'b0, 40);
        rd(4'h8, 4'h3);
        src_u.drive(1'b1, 40);
        src_u.drive(1'b0, 40);
        rd(4'h8, 4'h2);
        wr(4'h0, 4'h4);
        wr(4'h5, 4'h1);
        wr(4'h4, 4'h0);
        wr(4'h2, 4'hf);
        rd(4'h8, 4'h0);
        src_u.drive(1'b1, 10);
        src_u.drive(1'b0, 10);
        rd(4'h9, 4'h1);
        rd(4'h9, 4'h0);
        rd(4'h8, 4'hf);
        wr(4'h2, 4'hf);
        repeat (60) @(posedge ref_clk);
        rd(4'h9, 4'h1);
        end_sim;
    end
endmodule
`default_nettype wire
